/* File: src/mon_cfg_pkg.sv */
// Constants, reset values and state encodings of the monitor configuration block
package mon_cfg_pkg;

    // ****************
    // Register offsets
    // ****************
    localparam logic [7:0] ADDR_FAN_DIV = 8'h05;
    localparam logic [7:0] ADDR_OS_CFG = 8'h06;
    localparam logic [7:0] ADDR_DELAY_SEL = 8'h07;
    localparam logic [7:0] ADDR_CHAN_DIS = 8'h08;
    localparam logic [7:0] ADDR_DELAY_COUNT = 8'h0b;

    // ****************
    // Reset values
    // ****************
    localparam logic [7:0] RST_FAN_DIV = 8'h14;
    localparam logic [3:0] RST_OS_CFG_LOW = 4'h1;
    localparam logic [7:0] RST_DELAY_SEL = 8'h40;
    localparam logic [7:0] RST_CHAN_DIS = 8'h00;
    localparam logic [7:0] RST_DELAY_COUNT = 8'h40;

    // ****************
    // Field positions
    // ****************
    localparam int FAN_MODE_LSB = 0;
    localparam int FIRST_FAN_INPUT_CODE_LSB = 2;
    localparam int SECOND_FAN_INPUT_CODE_LSB = 4;
    localparam int PIN_OS_EN_BIT = 6;
    localparam int PIN_RST_EN_BIT = 7;
    localparam int OS_POL_BIT = 1;
    localparam int OS_ONE_TIME_BIT = 2;
    localparam int TEMP_HIRES_BIT = 3;
    localparam int TEMP_FRAC_LSB = 4;
    localparam int FIXED_DELAY_BIT = 0;
    localparam int TEMP_SLOT = 7;

    // ****************
    // Fan speed field codes
    // ****************
    localparam logic [1:0] FAN_CODE_DIV1 = 2'h0;
    localparam logic [1:0] FAN_CODE_DIV2 = 2'h1;
    localparam logic [1:0] FAN_CODE_DIV4 = 2'h2;
    localparam logic [1:0] FAN_CODE_ACT_LOW = 2'h1;

    // ****************
    // Timing
    // ****************
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 10;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int UNIT_DELAY_US = 1420;
    localparam int UNIT_DELAY_TICKS = UNIT_DELAY_US / TICK_US;
    localparam int FIXED_DELAY_MS = 728;
    localparam int FIXED_DELAY_TICKS = (FIXED_DELAY_MS * 1000) / TICK_US;
    localparam int DELAY_MUL = 8;
    localparam int DELAY_ADD = 6;
    localparam int RST_PULSE_US = 10;
    localparam int RST_PULSE_CYCLES = RST_PULSE_US * CLK_MHZ;

    // ****************
    // Scan sequencer states
    // ****************
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_PICK = 2'b01,
        SCAN_BUSY = 2'b10,
        SCAN_WAIT = 2'b11
    } scan_state_e;

endpackage : mon_cfg_pkg

/* File: src/delay_if.sv */
// Link between the scan sequencer and the monitoring delay timer
`timescale 1ns/1ps
interface delay_if;
    logic round_done;
    logic round_start;
    logic fixed_sel;
    logic [7:0] count_n;

    modport core (output round_done, output fixed_sel, output count_n, input round_start);
    modport timer (input round_done, input fixed_sel, input count_n, output round_start);
endinterface : delay_if

/* File: src/monitor_delay_timer.sv */
// Timer that waits the monitoring delay between two scan rounds
`timescale 1ns/1ps
module monitor_delay_timer #(
    parameter int UNIT_TICKS = mon_cfg_pkg::UNIT_DELAY_TICKS,
    parameter int FIXED_TICKS = mon_cfg_pkg::FIXED_DELAY_TICKS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Sequencer side
    delay_if.timer dly
);

    logic [9:0] pre_q;
    logic tick;
    logic running_q;
    logic [18:0] left_q;
    logic [31:0] prog_ticks;
    logic [18:0] load_ticks;
    logic start_q;

    // Ticks of the programmable delay, unit times (8 N + 6)
    always_comb begin
        prog_ticks = 32'(UNIT_TICKS) * (32'(mon_cfg_pkg::DELAY_MUL) * {24'h0, dly.count_n}
                     + 32'(mon_cfg_pkg::DELAY_ADD));
        load_ticks = dly.fixed_sel ? 19'(FIXED_TICKS) : prog_ticks[18:0];
    end

    // Base tick prescaler, restarted with each delay
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pre_q <= 10'h000;
        end else if (dly.round_done || tick) begin
            pre_q <= 10'h000;
        end else if (running_q) begin
            pre_q <= pre_q + 10'h001;
        end
    end
    assign tick = running_q && (pre_q == 10'(mon_cfg_pkg::TICK_CYCLES - 1));

    // Delay countdown
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            running_q <= 1'b0;
            left_q <= 19'h00000;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (dly.round_done) begin
                running_q <= 1'b1;
                left_q <= load_ticks;
            end else if (running_q && (left_q == 19'h00000)) begin
                running_q <= 1'b0;
                start_q <= 1'b1;
            end else if (tick) begin
                left_q <= left_q - 19'h00001;
            end
        end
    end

    assign dly.round_start = start_q;

endmodule : monitor_delay_timer

/* File: src/monitor_fan_os_rate_config.sv */
// Fan mode, shared pin, resolution, monitoring delay and channel disable registers
//
// Contract
// - Bit 0 set: first fan level mode
// - Bit 1 set: second fan level mode
// - Speed code selects divide 1, 2, 4, 8
// - First fan level: 01 low, 00 high
// - Second fan level: 01 low, 00 high
// - Bit 6 only: pin is overtemperature output
// - Bit 7 only: pin is reset output
// - Bits 6 and 7 set: pin disabled
// - Status bit 0 mirrors pin in overtemperature mode
// - Bit 1 sets overtemperature output polarity
// - Bit 2 selects one-time or comparator mode
// - Bit 3 selects 11-bit plus sign resolution
// - Bits 7:4 hold low temperature bits
// - Programmable delay 1.42 times (8N + 6) ms
// - Fixed delay bit gives 728 ms
// - Disabled analog channel: no conversions, errors, reading
// - Bit 7 disables temperature likewise
// - Count register supplies N, ignored when fixed
// - Reset request pulses pin low in reset mode
`timescale 1ns/1ps
module monitor_fan_os_rate_config #(
    parameter int UNIT_TICKS = mon_cfg_pkg::UNIT_DELAY_TICKS,
    parameter int FIXED_TICKS = mon_cfg_pkg::FIXED_DELAY_TICKS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Register access from the serial interface logic
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Fan pins and fan results
    input wire logic i_first_fan_input,
    input wire logic i_second_fan_input,
    output logic [1:0] o_fan_count_pulse,
    output logic [1:0] o_fan_level_active,
    output logic [1:0] o_fan_level_mode,
    // Temperature path
    input wire logic i_temp_over,
    input wire logic i_temp_frac_valid,
    input wire logic [3:0] i_temp_frac,
    output logic o_temp_hi_res,
    // Software reset request
    input wire logic i_sw_reset_req,
    output logic o_sw_reset_clear,
    // Shared reset / overtemperature pin
    output logic o_pin_out,
    output logic o_pin_oe,
    // Scan sequencer
    input wire logic i_monitor_enable,
    input wire logic i_conv_done,
    output logic o_conv_start,
    output logic [2:0] o_conv_chan,
    // Channel disable and limit errors
    input wire logic [7:0] i_limit_err,
    output logic [7:0] o_chan_disable,
    output logic [7:0] o_limit_err
);

    // ****************
    // Registers
    // ****************
    logic [7:0] fan_div_q;
    logic os_pol_q;
    logic os_one_time_q;
    logic temp_hires_q;
    logic [3:0] temp_frac_q;
    logic [7:0] delay_sel_q;
    logic [7:0] chan_dis_q;
    logic [7:0] delay_count_q;
    logic [7:0] rdata_q;
    logic wr_fan;
    logic wr_os;
    logic rd_os;
    logic os_mode;
    logic rst_mode;
    logic os_status;

    assign wr_fan = i_reg_wr && (i_reg_addr == mon_cfg_pkg::ADDR_FAN_DIV);
    assign wr_os = i_reg_wr && (i_reg_addr == mon_cfg_pkg::ADDR_OS_CFG);
    assign rd_os = i_reg_rd && (i_reg_addr == mon_cfg_pkg::ADDR_OS_CFG);

    // Fan divisor and pin select register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fan_div_q <= mon_cfg_pkg::RST_FAN_DIV;
        end else if (wr_fan) begin
            fan_div_q <= i_reg_wdata;
        end
    end

    // Overtemperature configuration; converter update of the low bits wins over a write
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            os_pol_q <= mon_cfg_pkg::RST_OS_CFG_LOW[mon_cfg_pkg::OS_POL_BIT];
            os_one_time_q <= mon_cfg_pkg::RST_OS_CFG_LOW[mon_cfg_pkg::OS_ONE_TIME_BIT];
            temp_hires_q <= mon_cfg_pkg::RST_OS_CFG_LOW[mon_cfg_pkg::TEMP_HIRES_BIT];
            temp_frac_q <= 4'h0;
        end else begin
            if (wr_os) begin
                os_pol_q <= i_reg_wdata[mon_cfg_pkg::OS_POL_BIT];
                os_one_time_q <= i_reg_wdata[mon_cfg_pkg::OS_ONE_TIME_BIT];
                temp_hires_q <= i_reg_wdata[mon_cfg_pkg::TEMP_HIRES_BIT];
            end
            if (i_temp_frac_valid && !chan_dis_q[mon_cfg_pkg::TEMP_SLOT]) begin
                temp_frac_q <= i_temp_frac;
            end else if (wr_os) begin
                temp_frac_q <= i_reg_wdata[mon_cfg_pkg::TEMP_FRAC_LSB +: 4];
            end
        end
    end

    // Delay select, channel disable and delay count registers
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            delay_sel_q <= mon_cfg_pkg::RST_DELAY_SEL;
            chan_dis_q <= mon_cfg_pkg::RST_CHAN_DIS;
            delay_count_q <= mon_cfg_pkg::RST_DELAY_COUNT;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                mon_cfg_pkg::ADDR_DELAY_SEL: begin
                    delay_sel_q <= i_reg_wdata;
                end
                mon_cfg_pkg::ADDR_CHAN_DIS: begin
                    chan_dis_q <= i_reg_wdata;
                end
                mon_cfg_pkg::ADDR_DELAY_COUNT: begin
                    delay_count_q <= i_reg_wdata;
                end
                default: begin
                    delay_sel_q <= delay_sel_q;
                end
            endcase
        end
    end

    // Read data, captured on the read strobe; unmapped offsets read zero
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_q <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                mon_cfg_pkg::ADDR_FAN_DIV: begin
                    rdata_q <= fan_div_q;
                end
                mon_cfg_pkg::ADDR_OS_CFG: begin
                    rdata_q <= {temp_frac_q, temp_hires_q, os_one_time_q, os_pol_q, os_status};
                end
                mon_cfg_pkg::ADDR_DELAY_SEL: begin
                    rdata_q <= delay_sel_q;
                end
                mon_cfg_pkg::ADDR_CHAN_DIS: begin
                    rdata_q <= chan_dis_q;
                end
                mon_cfg_pkg::ADDR_DELAY_COUNT: begin
                    rdata_q <= delay_count_q;
                end
                default: begin
                    rdata_q <= 8'h00;
                end
            endcase
        end
    end

    // ****************
    // Fan inputs
    // ****************
    logic [1:0] fan_pin;
    assign fan_pin = {i_second_fan_input, i_first_fan_input};

    // One synchroniser, prescaler and level decoder per fan
    for (genvar f = 0; f < 2; f++) begin : g_fan
        logic [2:0] sync_q;
        logic [2:0] div_cnt_q;
        logic [1:0] code;
        logic [2:0] div_last;
        logic level_mode;
        logic rise;

        assign code = fan_div_q[mon_cfg_pkg::FIRST_FAN_INPUT_CODE_LSB + 2 * f +: 2];
        assign level_mode = fan_div_q[mon_cfg_pkg::FAN_MODE_LSB + f];
        assign rise = sync_q[1] && !sync_q[2];

        // Prescale last count for divide by 1, 2, 4, 8
        always_comb begin
            case (code)
                mon_cfg_pkg::FAN_CODE_DIV1: div_last = 3'h0;
                mon_cfg_pkg::FAN_CODE_DIV2: div_last = 3'h1;
                mon_cfg_pkg::FAN_CODE_DIV4: div_last = 3'h3;
                default: div_last = 3'h7;
            endcase
        end

        // Two-stage synchroniser plus an edge stage
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                sync_q <= 3'h0;
            end else begin
                sync_q <= {sync_q[1:0], fan_pin[f]};
            end
        end

        // Counting mode prescaler, cleared while in level mode
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                div_cnt_q <= 3'h0;
                o_fan_count_pulse[f] <= 1'b0;
            end else begin
                o_fan_count_pulse[f] <= 1'b0;
                if (level_mode) begin
                    div_cnt_q <= 3'h0;
                end else if (rise) begin
                    if (div_cnt_q >= div_last) begin
                        div_cnt_q <= 3'h0;
                        o_fan_count_pulse[f] <= 1'b1;
                    end else begin
                        div_cnt_q <= div_cnt_q + 3'h1;
                    end
                end
            end
        end

        // Level mode active flag with selected polarity
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                o_fan_level_active[f] <= 1'b0;
                o_fan_level_mode[f] <= 1'b0;
            end else begin
                o_fan_level_mode[f] <= level_mode;
                o_fan_level_active[f] <= level_mode &&
                    ((code == mon_cfg_pkg::FAN_CODE_ACT_LOW) ? !sync_q[1] : sync_q[1]);
            end
        end
    end

    // ****************
    // Shared reset / overtemperature pin
    // ****************
    logic over_gated;
    logic over_prev_q;
    logic os_latch_q;
    logic os_active;
    logic rst_pulse_q;
    logic [9:0] rst_cnt_q;
    logic clear_q;

    assign os_mode = fan_div_q[mon_cfg_pkg::PIN_OS_EN_BIT] && !fan_div_q[mon_cfg_pkg::PIN_RST_EN_BIT];
    assign rst_mode = fan_div_q[mon_cfg_pkg::PIN_RST_EN_BIT] && !fan_div_q[mon_cfg_pkg::PIN_OS_EN_BIT];
    assign over_gated = i_temp_over && !chan_dis_q[mon_cfg_pkg::TEMP_SLOT];
    assign os_active = os_one_time_q ? os_latch_q : over_gated;
    assign os_status = os_mode ? o_pin_out : 1'b1;

    // One-time event latch: set on a new overtemperature, cleared by reading; set wins
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            over_prev_q <= 1'b0;
            os_latch_q <= 1'b0;
        end else begin
            over_prev_q <= over_gated;
            if (over_gated && !over_prev_q) begin
                os_latch_q <= 1'b1;
            end else if (rd_os) begin
                os_latch_q <= 1'b0;
            end
        end
    end

    // Software reset pulse; request ignored unless the pin is in reset mode
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_pulse_q <= 1'b0;
            rst_cnt_q <= 10'h000;
            clear_q <= 1'b0;
        end else begin
            clear_q <= 1'b0;
            if (rst_pulse_q) begin
                if (rst_cnt_q == 10'(mon_cfg_pkg::RST_PULSE_CYCLES - 1)) begin
                    rst_pulse_q <= 1'b0;
                    clear_q <= 1'b1;
                end else begin
                    rst_cnt_q <= rst_cnt_q + 10'h001;
                end
            end else if (i_sw_reset_req && rst_mode && !clear_q) begin
                rst_pulse_q <= 1'b1;
                rst_cnt_q <= 10'h000;
            end
        end
    end

    // Pin drive per selected function
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pin_out <= 1'b1;
            o_pin_oe <= 1'b0;
        end else if (os_mode) begin
            o_pin_out <= os_pol_q ? os_active : !os_active;
            o_pin_oe <= 1'b1;
        end else if (rst_mode) begin
            o_pin_out <= !rst_pulse_q;
            o_pin_oe <= 1'b1;
        end else begin
            o_pin_out <= 1'b1;
            o_pin_oe <= 1'b0;
        end
    end

    // ****************
    // Scan sequencer and delay timer
    // ****************
    delay_if dly ();
    mon_cfg_pkg::scan_state_e state_q;
    logic [2:0] slot_q;
    logic done_q;

    assign dly.round_done = done_q;
    assign dly.fixed_sel = delay_sel_q[mon_cfg_pkg::FIXED_DELAY_BIT];
    assign dly.count_n = delay_count_q;

    monitor_delay_timer #(
        .UNIT_TICKS(UNIT_TICKS),
        .FIXED_TICKS(FIXED_TICKS)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .dly(dly)
    );

    // Walk slots 0..7 in order, skipping disabled ones, then wait the delay
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= mon_cfg_pkg::SCAN_IDLE;
            slot_q <= 3'h0;
            done_q <= 1'b0;
            o_conv_start <= 1'b0;
            o_conv_chan <= 3'h0;
        end else begin
            done_q <= 1'b0;
            o_conv_start <= 1'b0;
            case (state_q)
                mon_cfg_pkg::SCAN_IDLE: begin
                    slot_q <= 3'h0;
                    if (i_monitor_enable) begin
                        state_q <= mon_cfg_pkg::SCAN_PICK;
                    end
                end
                mon_cfg_pkg::SCAN_PICK: begin
                    if (!i_monitor_enable) begin
                        state_q <= mon_cfg_pkg::SCAN_IDLE;
                    end else if (!chan_dis_q[slot_q]) begin
                        o_conv_start <= 1'b1;
                        o_conv_chan <= slot_q;
                        state_q <= mon_cfg_pkg::SCAN_BUSY;
                    end else if (slot_q == 3'(mon_cfg_pkg::TEMP_SLOT)) begin
                        done_q <= 1'b1;
                        state_q <= mon_cfg_pkg::SCAN_WAIT;
                    end else begin
                        slot_q <= slot_q + 3'h1;
                    end
                end
                mon_cfg_pkg::SCAN_BUSY: begin
                    if (i_conv_done) begin
                        if (slot_q == 3'(mon_cfg_pkg::TEMP_SLOT)) begin
                            done_q <= 1'b1;
                            state_q <= mon_cfg_pkg::SCAN_WAIT;
                        end else begin
                            slot_q <= slot_q + 3'h1;
                            state_q <= mon_cfg_pkg::SCAN_PICK;
                        end
                    end
                end
                mon_cfg_pkg::SCAN_WAIT: begin
                    slot_q <= 3'h0;
                    if (dly.round_start) begin
                        state_q <= i_monitor_enable ? mon_cfg_pkg::SCAN_PICK : mon_cfg_pkg::SCAN_IDLE;
                    end
                end
                default: begin
                    state_q <= mon_cfg_pkg::SCAN_IDLE;
                end
            endcase
        end
    end

    // ****************
    // Channel disable outputs and error masking
    // ****************
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_chan_disable <= 8'h00;
            o_limit_err <= 8'h00;
        end else begin
            o_chan_disable <= chan_dis_q;
            o_limit_err <= i_limit_err & ~chan_dis_q;
        end
    end

    // Registered outputs
    assign o_reg_rdata = rdata_q;
    assign o_temp_hi_res = temp_hires_q;
    assign o_sw_reset_clear = clear_q;

endmodule : monitor_fan_os_rate_config

/* File: tb/mon_cfg_assertions.sv */
// Port checks of the monitor configuration block
`timescale 1ns/1ps
module mon_cfg_assertions (
    // Watched ports
    input wire logic i_clk, i_rst_b, i_reg_wr, i_reg_rd, i_sw_reset_req, o_sw_reset_clear,
    input wire logic o_pin_out, o_pin_oe, o_temp_hi_res, o_conv_start,
    input wire logic [1:0] o_fan_level_mode,
    input wire logic [2:0] o_conv_chan,
    input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_limit_err, o_chan_disable, o_limit_err
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Write strobes per offset
    wire logic w5 = i_reg_wr && i_reg_addr == 8'h05;
    wire logic w6 = i_reg_wr && i_reg_addr == 8'h06;
    wire logic w8 = i_reg_wr && i_reg_addr == 8'h08;
    a_fan_mode_copy: assert property (w5 |-> ##2 o_fan_level_mode == $past(i_reg_wdata[1:0], 2))
        else $error("fan mode late");
    a_pin_mode_sel: assert property (w5 |-> ##2 o_pin_oe == ($past(i_reg_wdata[6], 2) ^ $past(i_reg_wdata[7], 2)))
        else $error("pin mode wrong");
    a_pin_off_high: assert property (!o_pin_oe |-> o_pin_out)
        else $error("idle pin low");
    a_hires_copy: assert property (w6 |-> ##2 o_temp_hi_res == $past(i_reg_wdata[3], 2))
        else $error("resolution late");
    a_dis_copy: assert property (w8 |-> ##2 o_chan_disable == $past(i_reg_wdata, 2))
        else $error("disable late");
    a_err_masked: assert property ($past(i_rst_b) |-> o_limit_err == ($past(i_limit_err) & ~o_chan_disable))
        else $error("error not masked");
    a_skip_disabled: assert property (o_conv_start |-> !o_chan_disable[o_conv_chan])
        else $error("disabled slot started");
    a_clear_has_req: assert property (o_sw_reset_clear |-> $past(i_sw_reset_req) && o_pin_oe)
        else $error("clear without request");
    a_unmapped_zero: assert property (i_reg_rd && !(i_reg_addr inside {8'h05, 8'h06, 8'h07, 8'h08, 8'h0b})
        |=> o_reg_rdata == 8'h00) else $error("unmapped read");
endmodule : mon_cfg_assertions
bind monitor_fan_os_rate_config mon_cfg_assertions u_chk (.*);

/* File: tb/mon_cfg_host.sv */
// Register host issuing one-cycle read and write strobes
`timescale 1ns/1ps
module mon_cfg_host (
    // Clock and read data
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    // Strobes, offset and data
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output logic [7:0] o_addr = 8'h00,
    output logic [7:0] o_wdata = 8'h00
);
    // Write; reserved rate bits always go out as zero
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= (a == 8'h07) ? (v & 8'h01) : v;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask : wr
    // Read; data is taken one edge after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        @(posedge i_clk);
        v = i_rdata;
    endtask : rd
endmodule : mon_cfg_host

/* File: tb/tb_monitor_fan_os_rate_config.sv */
// Self-checking bench of the monitor configuration block
`timescale 1ns/1ps
module tb_monitor_fan_os_rate_config;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_first_fan_input = 1'b0, i_second_fan_input = 1'b0, i_temp_over = 1'b0;
    logic i_temp_frac_valid = 1'b0, i_sw_reset_req = 1'b0, i_monitor_enable = 1'b0, i_conv_done = 1'b0;
    logic i_reg_wr, i_reg_rd, o_temp_hi_res, o_sw_reset_clear, o_pin_out, o_pin_oe, o_conv_start;
    logic [1:0] o_fan_count_pulse, o_fan_level_active, o_fan_level_mode;
    logic [2:0] o_conv_chan;
    logic [3:0] i_temp_frac = 4'h0;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_chan_disable, o_limit_err, d, r, r5, r6;
    logic [7:0] i_limit_err = 8'h4d, p0 = 8'h00, p1 = 8'h00;
    logic [7:0] ra [6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h0b, 8'h09};
    logic [7:0] rv [6] = '{8'h14, 8'h01, 8'h40, 8'h00, 8'h40, 8'h00};
    int mismatches = 0, tests_run = 0, n, m;
    monitor_fan_os_rate_config #(.UNIT_TICKS(1), .FIXED_TICKS(5)) DUT (.*);
    mon_cfg_host h (.i_clk, .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr),
        .o_wdata(i_reg_wdata));
    always #5 i_clk = ~i_clk;
    // Converter answers each start next edge; error events churn; fan pulses are tallied
    always @(posedge i_clk) begin
        i_conv_done <= o_conv_start;
        i_limit_err <= lf(i_limit_err);
        p0 <= p0 + {7'h0, o_fan_count_pulse[0]};
        p1 <= p1 + {7'h0, o_fan_count_pulse[1]};
    end
    function automatic logic [7:0] lf(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lf
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // Counts starts of one round and the gap from the last slot to the next round
    task automatic scan_round(output int gap, output int nst);
        logic seen7;
        gap = 0;
        nst = 0;
        seen7 = 1'b0;
        for (int k = 0; k < 40000; k++) begin
            @(posedge i_clk);
            gap += seen7;
            if (o_conv_start === 1'b1) begin
                if (seen7) return;
                nst++;
                seen7 = (o_conv_chan === 3'h7);
            end
        end
        mismatches++;
        tally_and_finish();
    endtask : scan_round
    initial begin
        r = 8'h4d;
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            h.rd(ra[k], d);
            chk(d, rv[k]);
        end
        // Random settings read back and seen at the outputs
        for (int k = 0; k < 16; k++) begin
            r5 = lf(r);
            r6 = lf(r5);
            r = lf(r6);
            h.wr(8'h05, r5);
            h.wr(8'h06, r6);
            h.wr(8'h08, r);
            h.rd(8'h06, d);
            chk(d, {r6[7:1], (r5[6] & ~r5[7]) ? ~r6[1] : 1'b1});
            chk({o_pin_oe, o_temp_hi_res, o_fan_level_mode, 4'h0}, {r5[6] ^ r5[7], r6[3], r5[1:0], 4'h0});
            chk(o_chan_disable, r);
            h.wr(8'h07, r5);
            h.rd(8'h07, d);
            chk(d, {7'h0, r5[0]});
        end
        // Every divide code on both fans, counter cleared by level mode first
        for (int c = 0; c < 4; c++) begin
            h.wr(8'h05, 8'h03);
            h.wr(8'h05, {2'h0, c[1:0], c[1:0], 2'h0});
            n = p0;
            m = p1;
            repeat (8) begin
                i_first_fan_input <= 1'b1;
                i_second_fan_input <= 1'b1;
                repeat (3) @(posedge i_clk);
                i_first_fan_input <= 1'b0;
                i_second_fan_input <= 1'b0;
                repeat (3) @(posedge i_clk);
            end
            repeat (6) @(posedge i_clk);
            chk(p0 - n[7:0], 8'h08 >> c);
            chk(p1 - m[7:0], 8'h08 >> c);
        end
        h.wr(8'h05, 8'h17);
        repeat (4) @(posedge i_clk);
        chk({6'h0, o_fan_level_active}, 8'h03);
        h.wr(8'h05, 8'h03);
        repeat (4) @(posedge i_clk);
        chk({6'h0, o_fan_level_active}, 8'h00);
        // Converter fraction load, then comparator and one-time pin behaviour
        h.wr(8'h08, 8'h0a);
        i_temp_frac <= 4'h9;
        i_temp_frac_valid <= 1'b1;
        @(posedge i_clk) i_temp_frac_valid <= 1'b0;
        h.rd(8'h06, d);
        chk({4'h0, d[7:4]}, 8'h09);
        h.wr(8'h05, 8'h40);
        h.wr(8'h06, 8'h00);
        i_temp_over <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk({7'h0, o_pin_out}, 8'h00);
        h.rd(8'h06, d);
        chk({7'h0, d[0]}, 8'h00);
        h.wr(8'h06, 8'h06);
        i_temp_over <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_temp_over <= 1'b1;
        @(posedge i_clk) i_temp_over <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk({7'h0, o_pin_out}, 8'h01);
        h.rd(8'h06, d);
        repeat (3) @(posedge i_clk);
        chk({7'h0, o_pin_out}, 8'h00);
        // Software reset pulse length on the shared pin
        h.wr(8'h05, 8'h80);
        i_sw_reset_req <= 1'b1;
        m = 0;
        for (n = 0; n < 3000 && o_sw_reset_clear !== 1'b1; n++) begin
            @(posedge i_clk);
            m += (o_pin_out === 1'b0);
        end
        i_sw_reset_req <= 1'b0;
        chk({7'h0, m inside {[999:1001]}}, 8'h01);
        // Scan with two slots off: programmable, then fixed delay
        h.wr(8'h0b, 8'h00);
        h.wr(8'h07, 8'h00);
        i_monitor_enable <= 1'b1;
        scan_round(n, m);
        chk(m[7:0], 8'h06);
        chk({7'h0, n inside {[6000:6010]}}, 8'h01);
        h.wr(8'h0b, 8'hff);
        h.wr(8'h07, 8'h01);
        scan_round(n, m);
        chk({7'h0, n inside {[5000:5010]}}, 8'h01);
        tally_and_finish();
    end
endmodule : tb_monitor_fan_os_rate_config
